/* bpl_gmux.sv */
// Output priority and registered drive of the six-pin second port.
// Assumes peripheral outputs and enables come from logic on the same clock.
`timescale 1ns/1ps
`include "bpl_regs.svh"
module bpl_gmux (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Port latch and direction.
  input wire logic [4:0] lat,
  input wire logic [4:0] dir,
  // Peripheral output functions.
  input wire logic cc3_out,
  input wire logic cc3_en,
  input wire logic cc4_out,
  input wire logic cc4_en,
  input wire logic cc5_out,
  input wire logic cc5_en,
  input wire logic ser_clk_out,
  input wire logic ser_clk_en,
  input wire logic ser_tx_out,
  input wire logic ser_tx_en,
  input wire logic ser_data_out,
  input wire logic ser_data_en,
  // Registered pin drive.
  output logic [5:0] pin_out,
  output logic [5:0] pin_oe
);
  import bpl_pkg::*;

  bpl_mux_state_type q;
  bpl_mux_state_type d;
  logic [4:0] val;

  // Highest enabled function wins the pin, the latch comes last.
  always_comb begin
    val = lat;
    if (cc3_en) val[`BPL_PIN_CC3] = cc3_out;
    if (ser_clk_en) begin
      val[`BPL_PIN_SER_CLK] = ser_clk_out;
    end else if (ser_tx_en) begin
      val[`BPL_PIN_SER_CLK] = ser_tx_out;
    end
    if (ser_data_en) val[`BPL_PIN_SER_DATA] = ser_data_out;
    if (cc4_en) val[`BPL_PIN_CC4] = cc4_out;
    if (cc5_en) val[`BPL_PIN_CC5] = cc5_out;
    // Driver follows direction only; analog select never enters here.
    d.oe = {1'b0, ~dir};
    d.out = {1'b0, val & ~dir};
    if (rst) begin
      d.oe = 6'h00;
      d.out = 6'h00;
    end
  end

  // Drive registers.
  always_ff @(posedge clk) begin
    q <= d;
  end

  assign pin_out = q.out;
  assign pin_oe = q.oe;
endmodule // bpl_gmux

/* bpl_pins_model.sv */
// Model of the circuits outside both ports: what each pin wire settles to.
// Assumes an outside driver holds a level on every pin the block leaves undriven.
`timescale 1ns/1ps
module bpl_pins_model (
  // Drive from the block.
  input wire logic [7:0] f_out,
  input wire logic [7:0] f_oe,
  input wire logic [5:0] g_out,
  input wire logic [5:0] g_oe,
  // Levels forced from outside.
  input wire logic [7:0] f_ext,
  input wire logic [5:0] g_ext,
  // Resolved wire levels fed back to the block.
  output logic [7:0] f_lvl,
  output logic [5:0] g_lvl
);
  // A driving pin shows the block's value, any other pin the outside level.
  assign f_lvl = (f_oe & f_out) | (~f_oe & f_ext);
  assign g_lvl = (g_oe & g_out) | (~g_oe & g_ext);
endmodule // bpl_pins_model

/* bpl_pkg.sv */
// Types shared by the two-port GPIO block.
// Assumes bpl_regs.svh supplies the offsets and reset values.
package bpl_pkg;

  // One-hot register select decoded from the bus address.
  typedef enum logic [8:0] {
    BPL_REG_NONE = 9'h001,
    BPL_REG_F_LATCH = 9'h002,
    BPL_REG_F_ANSEL = 9'h004,
    BPL_REG_F_PINS = 9'h008,
    BPL_REG_F_DIR = 9'h010,
    BPL_REG_G_PINS = 9'h020,
    BPL_REG_G_DIR = 9'h040,
    BPL_REG_G_LATCH = 9'h080,
    BPL_REG_G_ANSEL = 9'h100
  } bpl_reg_type;

  // Two-stage synchroniser for all fourteen pins.
  typedef struct packed {
    logic [13:0] s1;
    logic [13:0] s2;
  } bpl_sync_state_type;

  // Registered drive of the second port.
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } bpl_mux_state_type;

  // Whole state of the top module.
  typedef struct packed {
    logic [7:0] f_lat;
    logic [7:0] f_ansel;
    logic [7:0] f_dir;
    logic [4:0] g_lat;
    logic [4:0] g_dir;
    logic [3:0] g_ansel;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] f_out;
    logic [7:0] f_oe;
    logic [7:0] f_dis;
    logic [5:0] g_dis;
  } bpl_top_state_type;

endpackage

/* bpl_regs.svh */
// Register offsets, reset values and field positions of the two-port GPIO block.
// Assumes byte addresses on an eight-bit APB address with one aligned word per register.
`ifndef BPL_REGS_SVH
`define BPL_REGS_SVH

// Byte offsets of the registers.
`define BPL_OFF_F_LATCH 8'h00
`define BPL_OFF_F_ANSEL 8'h04
`define BPL_OFF_G_PINS 8'h08
`define BPL_OFF_G_DIR 8'h0C
`define BPL_OFF_G_LATCH 8'h10
`define BPL_OFF_G_ANSEL 8'h14
`define BPL_OFF_F_PINS 8'h18
`define BPL_OFF_F_DIR 8'h1C

// Reset values.
`define BPL_F_ANSEL_RST 8'hFF
`define BPL_G_ANSEL_RST 4'hF
`define BPL_F_DIR_RST 8'hFF
`define BPL_G_DIR_RST 5'h1F
`define BPL_G_DIR_RO_ONE 8'h20

// Field positions.
`define BPL_KEEP_HI 15
`define BPL_KEEP_LO 8
`define BPL_BYTE_HI 7
`define BPL_G_DRV_HI 4
`define BPL_G_ANS_HI 4
`define BPL_G_ANS_LO 1
`define BPL_G_IN_ONLY 5
`define BPL_PIN_CC3 0
`define BPL_PIN_SER_CLK 1
`define BPL_PIN_SER_DATA 2
`define BPL_PIN_CC4 3
`define BPL_PIN_CC5 4

`endif

/* bpl_sync.sv */
// Two flip-flop synchroniser for the pin levels of both ports.
// Assumes the pins change with no relation to SYS_CLK.
`timescale 1ns/1ps
module bpl_sync (
  // Clock.
  input wire logic clk,
  // Asynchronous pin levels and their synchronised copy.
  input wire logic [13:0] pins_async,
  output logic [13:0] pins_sync
);
  import bpl_pkg::*;

  bpl_sync_state_type q;
  bpl_sync_state_type d;

  // The first stage feeds only the second stage.
  always_comb begin
    d.s1 = pins_async;
    d.s2 = q.s1;
  end

  // Pin levels carry no reset: they are unknown until sampled.
  always_ff @(posedge clk) begin
    q <= d;
  end

  assign pins_sync = q.s2;
endmodule // bpl_sync

/* bpl_top.sv */
// Two general-purpose bidirectional ports with latch, direction and analog select.
// Assumes an APB master on SYS_CLK and pins driven from outside the clock domain.
`timescale 1ns/1ps
`include "bpl_regs.svh"
// Function
// - Second port has six pins with readable levels; pins four to zero also have direction and latch.
// - Direction one disables the driver; zero drives the latch onto the pin.
// - Sixth pin of the second port is input only; its direction reads one.
// - Reading the pin register gives pin levels; writing it updates the latch.
// - Port writes read pins, modify addressed bits, store result in the latch.
// - Direction bits keep steering drivers while pins are in analog mode.
// - Analog pins read zero digitally and their input buffer is disabled.
// - Analog select never stops a pin driving its digital output value.
// - Every implemented analog-select bit of both ports resets to one.
// - With several output functions enabled, the highest priority one drives.
// - Second-port priorities: CC3; serial clock then transmit; serial data; CC4; CC5.
// - Peripheral outputs still control pins that are in analog mode.
// - Second-port pin register: bits five to zero, bit five read-only, upper zero.
// - Second-port direction: bits four to zero reset to one, bit five reads one.
// - Second-port latch: bits four to zero kept over resets, upper bits zero.
// - First-port latch: eight bits kept over resets, target of pin writes.
// - First-port analog select: eight bits, zero digital, one analog.
// - Second-port analog select holds bits four to one, others read zero.
// - First port has eight pins with direction one input, zero output.
module bpl_top (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // First port pins.
  input wire logic [7:0] FP_PIN_IN,
  output logic [7:0] FP_PIN_OUT,
  output logic [7:0] FP_PIN_OE,
  output logic [7:0] FP_DIG_IN_DIS,
  // Second port pins.
  input wire logic [5:0] SP_PIN_IN,
  output logic [5:0] SP_PIN_OUT,
  output logic [5:0] SP_PIN_OE,
  output logic [5:0] SP_DIG_IN_DIS,
  // Peripheral output functions of the second port.
  input wire logic CAPTURE_COMPARE_THREE_OUTPUT,
  input wire logic CAPTURE_COMPARE_THREE_ENABLE,
  input wire logic CAPTURE_COMPARE_FOUR_OUTPUT,
  input wire logic CAPTURE_COMPARE_FOUR_ENABLE,
  input wire logic CAPTURE_COMPARE_FIVE_OUTPUT,
  input wire logic CAPTURE_COMPARE_FIVE_ENABLE,
  input wire logic SERIAL_TWO_CLOCK_OUTPUT,
  input wire logic SERIAL_TWO_CLOCK_ENABLE,
  input wire logic SERIAL_TWO_TRANSMIT_OUTPUT,
  input wire logic SERIAL_TWO_TRANSMIT_ENABLE,
  input wire logic SERIAL_TWO_DATA_OUTPUT,
  input wire logic SERIAL_TWO_DATA_ENABLE
);
  import bpl_pkg::*;

  bpl_top_state_type q;
  bpl_top_state_type d;
  logic [13:0] pins_sync;
  logic [7:0] f_read;
  logic [5:0] g_read;
  logic [7:0] g_ansel_view;
  logic setup;
  logic access;
  bpl_reg_type sel;
  logic [31:0] rd_val;

  // Decodes a byte address into a one-hot register select.
  function automatic bpl_reg_type decode(input logic [7:0] a);
    case (a)
      `BPL_OFF_F_LATCH: decode = BPL_REG_F_LATCH;
      `BPL_OFF_F_ANSEL: decode = BPL_REG_F_ANSEL;
      `BPL_OFF_F_PINS: decode = BPL_REG_F_PINS;
      `BPL_OFF_F_DIR: decode = BPL_REG_F_DIR;
      `BPL_OFF_G_PINS: decode = BPL_REG_G_PINS;
      `BPL_OFF_G_DIR: decode = BPL_REG_G_DIR;
      `BPL_OFF_G_LATCH: decode = BPL_REG_G_LATCH;
      `BPL_OFF_G_ANSEL: decode = BPL_REG_G_ANSEL;
      default: decode = BPL_REG_NONE;
    endcase
  endfunction

  // Digital read of a pin: analog pins always read zero.
  function automatic logic [7:0] dig_read(input logic [7:0] pins, input logic [7:0] ansel);
    dig_read = pins & ~ansel;
  endfunction

  // Read-modify-write: bits set in the keep mask take the current pin read.
  function automatic logic [7:0] rmw(input logic [7:0] pins, input logic [31:0] wdata);
    logic [7:0] keep;
    keep = wdata[`BPL_KEEP_HI:`BPL_KEEP_LO];
    rmw = (pins & keep) | (wdata[`BPL_BYTE_HI:0] & ~keep);
  endfunction

  // Both ports pass through one two-stage synchroniser.
  bpl_sync u_sync (
    .clk(SYS_CLK),
    .pins_async({SP_PIN_IN, FP_PIN_IN}),
    .pins_sync(pins_sync)
  );

  // Second-port priority mux and drive registers.
  bpl_gmux u_gmux (
    .clk(SYS_CLK),
    .rst(SYS_RST),
    .lat(q.g_lat),
    .dir(q.g_dir),
    .cc3_out(CAPTURE_COMPARE_THREE_OUTPUT),
    .cc3_en(CAPTURE_COMPARE_THREE_ENABLE),
    .cc4_out(CAPTURE_COMPARE_FOUR_OUTPUT),
    .cc4_en(CAPTURE_COMPARE_FOUR_ENABLE),
    .cc5_out(CAPTURE_COMPARE_FIVE_OUTPUT),
    .cc5_en(CAPTURE_COMPARE_FIVE_ENABLE),
    .ser_clk_out(SERIAL_TWO_CLOCK_OUTPUT),
    .ser_clk_en(SERIAL_TWO_CLOCK_ENABLE),
    .ser_tx_out(SERIAL_TWO_TRANSMIT_OUTPUT),
    .ser_tx_en(SERIAL_TWO_TRANSMIT_ENABLE),
    .ser_data_out(SERIAL_TWO_DATA_OUTPUT),
    .ser_data_en(SERIAL_TWO_DATA_ENABLE),
    .pin_out(SP_PIN_OUT),
    .pin_oe(SP_PIN_OE)
  );

  // Bus phases, address decode and digital pin reads.
  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & q.pready;
  assign sel = decode(PADDR);
  assign g_ansel_view = {3'h0, q.g_ansel, 1'b0};
  assign f_read = dig_read(pins_sync[7:0], q.f_ansel);
  assign g_read = 6'(dig_read({2'h0, pins_sync[13:8]}, g_ansel_view));

  // Read value of the addressed register, unused bits as zero.
  always_comb begin
    case (sel)
      BPL_REG_F_LATCH: rd_val = {24'h00_0000, q.f_lat};
      BPL_REG_F_ANSEL: rd_val = {24'h00_0000, q.f_ansel};
      BPL_REG_F_PINS: rd_val = {24'h00_0000, f_read};
      BPL_REG_F_DIR: rd_val = {24'h00_0000, q.f_dir};
      BPL_REG_G_PINS: rd_val = {26'h000_0000, g_read};
      BPL_REG_G_DIR: rd_val = {24'h00_0000, `BPL_G_DIR_RO_ONE | {3'h0, q.g_dir}};
      BPL_REG_G_LATCH: rd_val = {27'h000_0000, q.g_lat};
      BPL_REG_G_ANSEL: rd_val = {24'h00_0000, g_ansel_view};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // Next state: bus answer, register writes, first-port drive and reset.
  always_comb begin
    d = q;
    // Answer is prepared during setup so the access phase needs no wait.
    d.pready = setup;
    d.pslverr = setup & (sel == BPL_REG_NONE);
    d.prdata = setup ? rd_val : 32'h0000_0000;
    if (access && PWRITE) begin
      case (sel)
        BPL_REG_F_LATCH: d.f_lat = PWDATA[`BPL_BYTE_HI:0];
        BPL_REG_F_ANSEL: d.f_ansel = PWDATA[`BPL_BYTE_HI:0];
        BPL_REG_F_PINS: d.f_lat = rmw(f_read, PWDATA);
        BPL_REG_F_DIR: d.f_dir = PWDATA[`BPL_BYTE_HI:0];
        BPL_REG_G_PINS: d.g_lat = 5'(rmw({2'h0, g_read}, PWDATA));
        BPL_REG_G_DIR: d.g_dir = PWDATA[`BPL_G_DRV_HI:0];
        BPL_REG_G_LATCH: d.g_lat = PWDATA[`BPL_G_DRV_HI:0];
        BPL_REG_G_ANSEL: d.g_ansel = PWDATA[`BPL_G_ANS_HI:`BPL_G_ANS_LO];
        default: d.g_lat = q.g_lat;
      endcase
    end
    // Pins follow the registers one edge later; analog select gates only the input buffers.
    d.f_oe = ~q.f_dir;
    d.f_out = q.f_lat & ~q.f_dir;
    d.f_dis = q.f_ansel;
    d.g_dis = g_ansel_view[5:0];
    // Latches keep their value over reset; everything else is defined.
    if (SYS_RST) begin
      d.f_ansel = `BPL_F_ANSEL_RST;
      d.g_ansel = `BPL_G_ANSEL_RST;
      d.f_dir = `BPL_F_DIR_RST;
      d.g_dir = `BPL_G_DIR_RST;
      d.prdata = 32'h0000_0000;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.f_out = 8'h00;
      d.f_oe = 8'h00;
      d.f_dis = `BPL_F_ANSEL_RST;
      d.g_dis = {1'b0, `BPL_G_ANSEL_RST, 1'b0};
    end
  end

  // State register.
  always_ff @(posedge SYS_CLK) begin
    q <= d;
  end

  // Outputs straight from the state register.
  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign FP_PIN_OUT = q.f_out;
  assign FP_PIN_OE = q.f_oe;
  assign FP_DIG_IN_DIS = q.f_dis;
  assign SP_DIG_IN_DIS = q.g_dis;

  // Checks on the bus answer, registers and pin drive.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  chk_ready_one_cycle: assert property (
    setup |=> PREADY ##1 !PREADY)
    else $error("PREADY did not pulse for exactly one cycle after setup");

  chk_unmapped_error: assert property (
    setup && sel == BPL_REG_NONE |=> PSLVERR && PRDATA == 32'h0000_0000)
    else $error("Unmapped address not answered with an error");

  chk_input_only_dir: assert property (
    setup && sel == BPL_REG_G_DIR |=> PRDATA[`BPL_G_IN_ONLY] && PRDATA[31:6] == 26'h000_0000)
    else $error("Second-port direction read lost its fixed one");

  chk_input_only_drive: assert property (
    !SP_PIN_OE[`BPL_G_IN_ONLY] && !SP_PIN_OUT[`BPL_G_IN_ONLY])
    else $error("Input-only pin is being driven");

  chk_latch_write: assert property (
    access && PWRITE && sel == BPL_REG_F_LATCH |=> q.f_lat == $past(PWDATA[7:0]))
    else $error("First-port latch did not take the written byte");

  chk_pin_write_latch: assert property (
    access && PWRITE && sel == BPL_REG_G_PINS && PWDATA[15:8] == 8'h00
    |=> q.g_lat == $past(PWDATA[4:0]))
    else $error("Pin register write did not land in the second-port latch");

  chk_analog_read_zero: assert property (
    setup && sel == BPL_REG_F_PINS |=> (PRDATA[7:0] & $past(q.f_ansel)) == 8'h00)
    else $error("Analog pin read back a nonzero digital value");

  chk_analog_drives: assert property (
    !q.f_dir[7] && q.f_ansel[7] |=> FP_PIN_OE[7] && FP_PIN_OUT[7] == $past(q.f_lat[7]))
    else $error("Analog-selected output pin stopped driving its latch");

  chk_dir_to_driver: assert property (
    access && PWRITE && sel == BPL_REG_F_DIR |=> ##1 FP_PIN_OE == ~$past(PWDATA[7:0], 2))
    else $error("First-port drivers did not follow a direction write");

  chk_cc3_priority: assert property (
    CAPTURE_COMPARE_THREE_ENABLE && !q.g_dir[0]
    |=> SP_PIN_OUT[0] == $past(CAPTURE_COMPARE_THREE_OUTPUT))
    else $error("Capture/compare three did not win pin zero");

  chk_ser_clock_first: assert property (
    SERIAL_TWO_CLOCK_ENABLE && SERIAL_TWO_TRANSMIT_ENABLE && !q.g_dir[1]
    |=> SP_PIN_OUT[1] == $past(SERIAL_TWO_CLOCK_OUTPUT))
    else $error("Serial clock did not take priority over transmit");

  chk_analog_reset: assert property (
    $fell(SYS_RST) |-> q.f_ansel == `BPL_F_ANSEL_RST && q.g_ansel == `BPL_G_ANSEL_RST)
    else $error("Analog select bits not all one after reset");

  // First-port input buffers follow the analog select one edge later.
  chk_first_in_off: assert property (
    !$past(SYS_RST) |-> FP_DIG_IN_DIS == $past(q.f_ansel))
    else $error("First-port input buffers do not follow analog select");

  // Second-port input buffers follow bits four to one only.
  chk_second_in_off: assert property (
    !$past(SYS_RST) |-> SP_DIG_IN_DIS == {1'b0, $past(q.g_ansel), 1'b0})
    else $error("Second-port input buffers do not follow analog select");

  // Second-port pin reads mask analog pins and clear the unused bits.
  chk_pin_read_mask: assert property (
    setup && sel == BPL_REG_G_PINS |=> PRDATA[31:6] == 26'h000_0000 && (PRDATA[4:1] & $past(q.g_ansel)) == 4'h0)
    else $error("Second-port pin read not masked");

  // Second-port analog select reads back with bit zero and upper bits clear.
  chk_select_readback: assert property (
    setup && sel == BPL_REG_G_ANSEL |=> PRDATA == {27'h000_0000, $past(q.g_ansel), 1'b0})
    else $error("Second-port analog select read back wrong");

  // Second-port latch reads back with the upper bits clear.
  chk_latch_readback: assert property (
    setup && sel == BPL_REG_G_LATCH |=> PRDATA == {27'h000_0000, $past(q.g_lat)})
    else $error("Second-port latch read back wrong");

  // Both direction registers come out of reset as all input.
  chk_dir_reset: assert property (
    $fell(SYS_RST) |-> q.g_dir == `BPL_G_DIR_RST && q.f_dir == `BPL_F_DIR_RST)
    else $error("Direction bits not all input after reset");

  // No driver is on and no answer is pending right after reset.
  chk_drive_reset: assert property (
    $fell(SYS_RST) |-> FP_PIN_OE == 8'h00 && SP_PIN_OE == 6'h00 && !PREADY)
    else $error("Drivers or bus answer active after reset");

  // Second-port direction write lands in the writable bits.
  chk_dir_write: assert property (
    access && PWRITE && sel == BPL_REG_G_DIR |=> q.g_dir == $past(PWDATA[4:0]))
    else $error("Second-port direction write lost");

  // First-port analog select write lands in full.
  chk_first_select_wr: assert property (
    access && PWRITE && sel == BPL_REG_F_ANSEL |=> q.f_ansel == $past(PWDATA[7:0]))
    else $error("First-port analog select write lost");

  // Second-port analog select write takes bits four to one.
  chk_second_select_wr: assert property (
    access && PWRITE && sel == BPL_REG_G_ANSEL |=> q.g_ansel == $past(PWDATA[4:1]))
    else $error("Second-port analog select write lost");

  // A write to no register leaves both latches alone.
  chk_unmapped_ignored: assert property (
    access && PWRITE && sel == BPL_REG_NONE |=> q.f_lat == $past(q.f_lat) && q.g_lat == $past(q.g_lat))
    else $error("Unmapped write changed a latch");

  // With no peripheral on it, an output pin drives its latch bit.
  chk_latch_drives: assert property (
    !q.g_dir[3] && !CAPTURE_COMPARE_FOUR_ENABLE |=> SP_PIN_OE[3] && SP_PIN_OUT[3] == $past(q.g_lat[3]))
    else $error("Output pin does not drive its latch bit");

  // A pin write with a full keep mask copies the digital pin read.
  chk_rmw_keep: assert property (
    access && PWRITE && sel == BPL_REG_F_PINS && PWDATA[15:8] == 8'hFF |=> q.f_lat == $past(f_read))
    else $error("Read-modify-write did not keep the pin read");

  // Pins set as input never have their driver on.
  chk_input_no_drive: assert property (
    1'b1 |=> (FP_PIN_OE & $past(q.f_dir)) == 8'h00)
    else $error("Input pin has its driver on");

  // Main scenarios.
  cov_pin_rmw_write: cover property (access && PWRITE && sel == BPL_REG_F_PINS);
  cov_g_pin_write: cover property (access && PWRITE && sel == BPL_REG_G_PINS);
  cov_analog_output: cover property (FP_PIN_OE[7] && FP_DIG_IN_DIS[7]);
  cov_cc3_override: cover property (CAPTURE_COMPARE_THREE_ENABLE && SP_PIN_OE[0]);
  cov_ser_both: cover property (SERIAL_TWO_CLOCK_ENABLE && SERIAL_TWO_TRANSMIT_ENABLE);
endmodule // bpl_top

/* bpl_top_tb.sv */
// Self-checking bench for the two-port GPIO block, driven over APB.
// Assumes bpl_regs.svh offsets and the pin model in bpl_pins_model.sv.
`timescale 1ns/1ps
`include "bpl_regs.svh"
module bpl_top_tb;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, fin, fout, foe, fdis, f_ext;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] gin, gout, goe, gdis, g_ext;
  logic [11:0] per;
  logic [11:0] p_tab [6] = '{12'hC00, 12'h300, 12'h0C0, 12'h030, 12'h00C, 12'h003};
  logic [5:0] e_tab [6] = '{6'h01, 6'h08, 6'h10, 6'h02, 6'h02, 6'h04};
  int n_fail, n_compared;

  // Block under test.
  bpl_top i_dut (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FP_PIN_IN(fin), .FP_PIN_OUT(fout), .FP_PIN_OE(foe),
    .FP_DIG_IN_DIS(fdis), .SP_PIN_IN(gin), .SP_PIN_OUT(gout), .SP_PIN_OE(goe),
    .SP_DIG_IN_DIS(gdis), .CAPTURE_COMPARE_THREE_OUTPUT(per[11]),
    .CAPTURE_COMPARE_THREE_ENABLE(per[10]), .CAPTURE_COMPARE_FOUR_OUTPUT(per[9]),
    .CAPTURE_COMPARE_FOUR_ENABLE(per[8]), .CAPTURE_COMPARE_FIVE_OUTPUT(per[7]),
    .CAPTURE_COMPARE_FIVE_ENABLE(per[6]), .SERIAL_TWO_CLOCK_OUTPUT(per[5]),
    .SERIAL_TWO_CLOCK_ENABLE(per[4]), .SERIAL_TWO_TRANSMIT_OUTPUT(per[3]),
    .SERIAL_TWO_TRANSMIT_ENABLE(per[2]), .SERIAL_TWO_DATA_OUTPUT(per[1]),
    .SERIAL_TWO_DATA_ENABLE(per[0]));

  // Outside world of the pins.
  bpl_pins_model i_pins (.f_out(fout), .f_oe(foe), .g_out(gout), .g_oe(goe),
    .f_ext(f_ext), .g_ext(g_ext), .f_lvl(fin), .g_lvl(gin));

  // Clock of 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Compares one result and counts it.
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    n_compared++;
    if (act !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  // One APB transfer; waits for pready under a bound.
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Lets n edges pass and steps past their updates.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Drives the peripheral outputs and enables.
  task automatic setp(input logic [11:0] v);
    @(posedge clk);
    per <= v;
    settle(1);
  endtask

  // Values after the first reset.
  task automatic t_reset;
    chk(32'(foe), 32'h0000_0000);
    chk(32'(goe), 32'h0000_0000);
    chk(32'(fdis), 32'h0000_00FF);
    chk(32'(gdis), 32'h0000_001E);
    rdchk(`BPL_OFF_F_ANSEL, 32'(`BPL_F_ANSEL_RST));
    rdchk(`BPL_OFF_G_ANSEL, 32'h0000_001E);
    rdchk(`BPL_OFF_G_DIR, 32'h0000_003F);
    rdchk(`BPL_OFF_F_DIR, 32'h0000_00FF);
  endtask

  // Pin reads with and without analog masking; all pins stay inputs.
  task automatic t_read;
    @(posedge clk);
    f_ext <= 8'hA5;
    g_ext <= 6'h2B;
    settle(3);
    rdchk(`BPL_OFF_F_PINS, 32'h0000_0000);
    rdchk(`BPL_OFF_G_PINS, 32'h0000_0021);
    wr(`BPL_OFF_F_ANSEL, 32'h0000_0000);
    wr(`BPL_OFF_G_ANSEL, 32'h0000_0000);
    rdchk(`BPL_OFF_G_ANSEL, 32'h0000_0000);
    rdchk(`BPL_OFF_F_PINS, 32'h0000_00A5);
    rdchk(`BPL_OFF_G_PINS, 32'h0000_002B);
    wr(`BPL_OFF_G_ANSEL, 32'h0000_00FF);
    rdchk(`BPL_OFF_G_ANSEL, 32'h0000_001E);
  endtask

  // Read-modify-write into the first latch, then drive it out.
  task automatic t_rmw;
    wr(`BPL_OFF_F_PINS, 32'h0000_0F30);
    rdchk(`BPL_OFF_F_LATCH, 32'h0000_0035);
    wr(`BPL_OFF_F_PINS, 32'h0000_003C);
    rdchk(`BPL_OFF_F_LATCH, 32'h0000_003C);
    wr(`BPL_OFF_F_ANSEL, 32'h0000_00F0);
    wr(`BPL_OFF_F_PINS, 32'h0000_FF00);
    rdchk(`BPL_OFF_F_LATCH, 32'h0000_0005);
    wr(`BPL_OFF_F_LATCH, 32'h0000_00C3);
    wr(`BPL_OFF_F_DIR, 32'h0000_0000);
    settle(3);
    chk(32'(foe), 32'h0000_00FF);
    chk(32'(fout), 32'h0000_00C3);
    chk(32'(fdis), 32'h0000_00F0);
    rdchk(`BPL_OFF_F_PINS, 32'h0000_0003);
    wr(`BPL_OFF_F_DIR, 32'h0000_00FF);
    settle(2);
    chk(32'(foe), 32'h0000_0000);
  endtask

  // Second port drive timing and the input-only pin.
  task automatic t_gport;
    wr(`BPL_OFF_G_LATCH, 32'h0000_00FF);
    rdchk(`BPL_OFF_G_LATCH, 32'h0000_001F);
    wr(`BPL_OFF_G_DIR, 32'h0000_0000);
    #1;
    chk(32'(goe), 32'h0000_0000);
    settle(1);
    chk(32'(goe), 32'h0000_001F);
    chk(32'(gout), 32'h0000_001F);
    rdchk(`BPL_OFF_G_DIR, 32'h0000_0020);
    wr(`BPL_OFF_G_PINS, 32'h0000_1F00);
    rdchk(`BPL_OFF_G_LATCH, 32'h0000_0001);
    wr(`BPL_OFF_G_PINS, 32'h0000_003F);
    rdchk(`BPL_OFF_G_LATCH, 32'h0000_001F);
  endtask

  // Output priority of peripherals over the latch on analog pins.
  task automatic t_prio;
    setp(12'h555);
    chk(32'(gout), 32'h0000_0000);
    setp(12'h01C);
    chk(32'(gout), 32'h0000_001D);
    setp(12'h004);
    chk(32'(gout), 32'h0000_001D);
    wr(`BPL_OFF_G_LATCH, 32'h0000_0000);
    setp(12'hAAA);
    chk(32'(gout), 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      setp(p_tab[i]);
      chk(32'(gout), 32'(e_tab[i]));
    end
    setp(12'h000);
  endtask

  // Unmapped address answers with an error and no data.
  task automatic t_unmapped;
    apb(1'b1, 8'h20, 32'h0000_00AA);
    chk(32'(err), 32'h0000_0001);
    rdchk(8'h20, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    rdchk(`BPL_OFF_G_LATCH, 32'h0000_0000);
    chk(32'(err), 32'h0000_0000);
  endtask

  // Second reset keeps the latches and restores the rest.
  task automatic t_reset_keep;
    wr(`BPL_OFF_G_LATCH, 32'h0000_0015);
    wr(`BPL_OFF_F_ANSEL, 32'h0000_0000);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdchk(`BPL_OFF_G_LATCH, 32'h0000_0015);
    rdchk(`BPL_OFF_F_LATCH, 32'h0000_00C3);
    rdchk(`BPL_OFF_F_ANSEL, 32'h0000_00FF);
    rdchk(`BPL_OFF_G_DIR, 32'h0000_003F);
    chk(32'(goe), 32'h0000_0000);
  endtask

  // Main sequence.
  initial begin
    n_fail = 0;
    n_compared = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    per = 12'h000;
    f_ext = 8'h00;
    g_ext = 6'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_read();
    t_rmw();
    t_gport();
    t_prio();
    t_unmapped();
    t_reset_keep();
    end_sim();
  end
endmodule // bpl_top_tb
